// ==== hdl/bpsst_core.sv ====
`timescale 1ns/10ps
// Summary of operation
// - Wait goes not-ready on select or strobe.
// - Wait goes ready at edge latency-1.
// - Deselect floats wait; host ignores it.
// - Burst starts at first edge of strobe.
// - Clock halt freezes burst; resume continues.
// - Output enable gates bus during suspend.
// - Burst read and async write interleave.
// - Burst read and write follow directly.
// - Beat with both lanes masked unwritten.
// - Latency five or four supported.
module bpsst_core #(
	parameter int LATENCY = bpsst_pkg::LATENCY_FAST,
	parameter int BURST_LEN = bpsst_pkg::BURST_LEN_DEF,
	parameter int ARRAY_AW = bpsst_pkg::ARRAY_AW_DEF
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic cs_n,
	input wire logic addr_valid_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic upper_lane_n,
	input wire logic lower_lane_n,
	input wire logic burst_write_mode,
	input wire logic [bpsst_pkg::ADDR_W-1:0] addr,
	input wire logic [bpsst_pkg::DATA_W-1:0] dq_in,
	output logic [bpsst_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe,
	output logic wait_n,
	output logic wait_oe,
	output logic burst_overrun,
	output logic proto_err
);

	localparam int LW = $clog2(LATENCY + 1);
	localparam int BW = $clog2(BURST_LEN + 1);
	localparam int OW = $clog2(BURST_LEN);
	localparam int SW = $clog2(bpsst_pkg::BURST_CYCLE_TIME_CYC + 2);
	localparam logic [LW-1:0] LAT_REL = LW'(LATENCY - 2);
	localparam logic [LW-1:0] LAT_LAST = LW'(LATENCY - 1);
	localparam logic [BW-1:0] BEAT_END = BW'(BURST_LEN);
	localparam logic [SW-1:0] SEL_MAX = SW'(bpsst_pkg::BURST_CYCLE_TIME_CYC);

	// Only the two documented latencies and the documented burst lengths are served.
	if (!(LATENCY == bpsst_pkg::LATENCY_FAST || LATENCY == bpsst_pkg::LATENCY_SLOW)) begin : g_bad_lat
		$error("LATENCY must be 4 or 5");
	end
	if (!(BURST_LEN == 4 || BURST_LEN == 8 || BURST_LEN == 16 || BURST_LEN == 256)) begin : g_bad_len
		$error("BURST_LEN must be 4, 8, 16 or 256");
	end
	if (ARRAY_AW < OW || ARRAY_AW > bpsst_pkg::ADDR_W) begin : g_bad_aw
		$error("ARRAY_AW out of range");
	end

	// Linear burst wraps inside its aligned group of BURST_LEN words.
	function automatic logic [bpsst_pkg::ADDR_W-1:0] next_addr(
		input logic [bpsst_pkg::ADDR_W-1:0] a
	);
		logic [OW-1:0] off;
		off = a[OW-1:0] + 1'h1;
		next_addr = {a[bpsst_pkg::ADDR_W-1:OW], off};
	endfunction : next_addr

	// The array holds fewer words than the pins address; upper bits alias.
	function automatic logic [ARRAY_AW-1:0] array_index(
		input logic [bpsst_pkg::ADDR_W-1:0] a
	);
		array_index = a[ARRAY_AW-1:0];
	endfunction : array_index

	bpsst_pkg::bpsst_state_t st_r;
	logic [LW-1:0] lat_cnt_r;
	logic [BW-1:0] beat_cnt_r;
	logic [bpsst_pkg::ADDR_W-1:0] burst_addr_r;
	logic [bpsst_pkg::ADDR_W-1:0] async_addr_r;
	logic [bpsst_pkg::DATA_W-1:0] dq_out_r;
	logic dq_valid_r;
	logic is_write_r;
	logic cs_prev_r;
	logic adv_prev_r;
	logic we_prev_r;
	logic wait_n_r;
	logic wait_oe_r;
	logic proto_err_r;
	logic burst_overrun_r;
	logic [SW-1:0] sel_cnt_r;
	logic cs_fall;
	logic adv_fall;
	logic at_rest;
	logic async_req;
	logic start;
	logic burst_beat;
	logic async_wr;
	logic mem_we;
	logic [bpsst_pkg::LANE_W-1:0] mem_lane;
	logic [ARRAY_AW-1:0] mem_waddr;
	logic [bpsst_pkg::DATA_W-1:0] mem_rdata;

	// Edge detection on synchronous pin samples; a low strobe held over many edges counts once.
	assign cs_fall = !cs_n && cs_prev_r;
	assign adv_fall = !addr_valid_n && adv_prev_r;
	assign at_rest = (st_r == bpsst_pkg::ST_IDLE) || (st_r == bpsst_pkg::ST_DONE);
	assign async_req = !we_n && !burst_write_mode;
	assign start = !cs_n && adv_fall && at_rest && !async_req;

	// Write beats come from the burst sequencer or from a write-enable release.
	assign burst_beat = !cs_n && is_write_r && (((st_r == bpsst_pkg::ST_LAT) &&
		(lat_cnt_r == LAT_LAST)) || ((st_r == bpsst_pkg::ST_WR) && (beat_cnt_r != BEAT_END)));
	assign async_wr = !cs_n && we_n && !we_prev_r && at_rest && !burst_write_mode;
	assign mem_lane = {!upper_lane_n, !lower_lane_n};
	assign mem_we = (burst_beat || async_wr) && (mem_lane != 2'h0);
	// Low-strobe style writes take the live address; latch style uses the held one.
	assign mem_waddr = burst_beat ? array_index(burst_addr_r) :
		array_index(addr_valid_n ? async_addr_r : addr);

	bpsst_array #(
		.AW(ARRAY_AW)
	) u_array (
		.mclk(mclk),
		.clk_en(clk_en),
		.wr_en(mem_we),
		.wr_lane(mem_lane),
		.wr_addr(mem_waddr),
		.wr_data(dq_in),
		.rd_addr(array_index(burst_addr_r)),
		.rd_data(mem_rdata)
	);

	// Previous pin levels for edge detection.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			cs_prev_r <= bpsst_pkg::PIN_HIGH_RST;
			adv_prev_r <= bpsst_pkg::PIN_HIGH_RST;
			we_prev_r <= bpsst_pkg::PIN_HIGH_RST;
		end else if (clk_en) begin
			cs_prev_r <= cs_n;
			adv_prev_r <= addr_valid_n;
			we_prev_r <= we_n;
		end
	end

	// Asynchronous-write address, captured whenever the strobe is low outside a burst.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			async_addr_r <= '0;
		end else if (clk_en && !cs_n && !addr_valid_n && at_rest) begin
			async_addr_r <= addr;
		end
	end

	// Burst sequencer; a stopped clock simply freezes it, which gives the read suspend.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			st_r <= bpsst_pkg::ST_IDLE;
			lat_cnt_r <= '0;
			beat_cnt_r <= '0;
			burst_addr_r <= '0;
			is_write_r <= 1'h0;
			dq_out_r <= '0;
			dq_valid_r <= 1'h0;
		end else if (clk_en) begin
			if (cs_n) begin
				st_r <= bpsst_pkg::ST_IDLE;
				dq_valid_r <= 1'h0;
				is_write_r <= 1'h0;
			end else if (start) begin
				st_r <= bpsst_pkg::ST_LAT;
				lat_cnt_r <= LW'(1);
				beat_cnt_r <= '0;
				burst_addr_r <= addr;
				is_write_r <= !we_n;
				dq_valid_r <= 1'h0;
			end else begin
				case (st_r)
					bpsst_pkg::ST_LAT: begin
						if (lat_cnt_r == LAT_LAST) begin
							beat_cnt_r <= BW'(1);
							burst_addr_r <= next_addr(burst_addr_r);
							if (is_write_r) begin
								st_r <= bpsst_pkg::ST_WR;
							end else begin
								st_r <= bpsst_pkg::ST_RD;
								dq_out_r <= mem_rdata;
								dq_valid_r <= 1'h1;
							end
						end else begin
							lat_cnt_r <= lat_cnt_r + 1'h1;
						end
					end
					bpsst_pkg::ST_RD, bpsst_pkg::ST_WR: begin
						if (beat_cnt_r == BEAT_END) begin
							// The last read word stays on the bus until deselect or a new strobe.
							st_r <= bpsst_pkg::ST_DONE;
						end else begin
							beat_cnt_r <= beat_cnt_r + 1'h1;
							burst_addr_r <= next_addr(burst_addr_r);
							if (st_r == bpsst_pkg::ST_RD) begin
								dq_out_r <= mem_rdata;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end
	end

	// Wait indicator: not-ready on select or strobe, ready one edge ahead of data.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			wait_n_r <= bpsst_pkg::PIN_HIGH_RST;
			wait_oe_r <= bpsst_pkg::PIN_LOW_RST;
		end else if (clk_en) begin
			if (cs_n) begin
				wait_oe_r <= 1'h0;
				wait_n_r <= 1'h1;
			end else if (cs_fall || adv_fall) begin
				wait_oe_r <= 1'h1;
				wait_n_r <= 1'h0;
			end else if (st_r == bpsst_pkg::ST_LAT && lat_cnt_r == LAT_REL) begin
				wait_n_r <= 1'h1;
			end
		end
	end

	// A strobe during a running burst is a host fault; it is flagged and the sequencer ignores it, but wait still goes not-ready.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			proto_err_r <= 1'h0;
		end else if (clk_en) begin
			proto_err_r <= !cs_n && adv_fall && !at_rest;
		end
	end

	// Selection watchdog; it only reports, since refresh starvation is the host's to avoid.
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			sel_cnt_r <= '0;
			burst_overrun_r <= 1'h0;
		end else if (clk_en) begin
			if (cs_n) begin
				sel_cnt_r <= '0;
				burst_overrun_r <= 1'h0;
			end else if (sel_cnt_r != SEL_MAX) begin
				sel_cnt_r <= sel_cnt_r + 1'h1;
			end else begin
				burst_overrun_r <= 1'h1;
			end
		end
	end

	// The data bus follows output enable live, so a suspended word can be re-shown or floated.
	assign dq_oe = dq_valid_r && !oe_n && !cs_n && !is_write_r;
	assign dq_out = dq_out_r;
	assign wait_n = wait_n_r;
	assign wait_oe = wait_oe_r;
	assign proto_err = proto_err_r;
	assign burst_overrun = burst_overrun_r;

	a_wait_on_select: assert property (@(posedge mclk) disable iff (!rst_b)
		(clk_en && !cs_n && (cs_fall || adv_fall)) |=> (!wait_n && wait_oe))
		else $error("wait not driven low after select or strobe");

	a_wait_release_edge: assert property (@(posedge mclk) disable iff (!rst_b)
		(clk_en && !cs_n && st_r == bpsst_pkg::ST_LAT && lat_cnt_r == LAT_REL) |=> wait_n)
		else $error("wait not released at latency minus one");

	a_wait_not_early: assert property (@(posedge mclk) disable iff (!rst_b)
		(st_r == bpsst_pkg::ST_LAT && lat_cnt_r < LAT_REL && wait_oe) |-> !wait_n)
		else $error("wait released before latency minus one");

	a_wait_float_desel: assert property (@(posedge mclk) disable iff (!rst_b)
		(clk_en && cs_n) |=> !wait_oe)
		else $error("wait still driven after deselect");

	a_start_first_edge: assert property (@(posedge mclk) disable iff (!rst_b)
		(clk_en && start) |=> (st_r == bpsst_pkg::ST_LAT && lat_cnt_r == LW'(1)))
		else $error("burst did not start on first strobe edge");

	a_first_data_lat: assert property (@(posedge mclk) disable iff (!rst_b)
		(clk_en && start && we_n) ##1 (clk_en && !cs_n)[*4] |->
		(dq_valid_r == (LATENCY == bpsst_pkg::LATENCY_SLOW)))
		else $error("first read word not at programmed latency");

	a_suspend_freeze: assert property (@(posedge mclk) disable iff (!rst_b)
		!clk_en |=> ($stable(dq_out_r) && $stable(st_r) && $stable(burst_addr_r)))
		else $error("state moved while clock halted");

	a_bus_gated_oe: assert property (@(posedge mclk) disable iff (!rst_b)
		dq_oe |-> (!oe_n && !is_write_r && st_r != bpsst_pkg::ST_LAT))
		else $error("data bus driven without output enable");

	a_mask_no_write: assert property (@(posedge mclk) disable iff (!rst_b)
		(upper_lane_n && lower_lane_n) |-> !mem_we)
		else $error("masked beat written");

	a_async_write_take: assert property (@(posedge mclk) disable iff (!rst_b)
		(clk_en && async_wr && !lower_lane_n) |=>
		(u_array.mem[$past(mem_waddr)][7:0] == $past(dq_in[7:0])))
		else $error("asynchronous write not taken");

	a_stop_to_idle: assert property (@(posedge mclk) disable iff (!rst_b)
		(clk_en && cs_n) |=> (st_r == bpsst_pkg::ST_IDLE && !dq_valid_r))
		else $error("deselect did not end burst");

endmodule : bpsst_core

// ==== hdl/bpsst_pkg.sv ====
package bpsst_pkg;

	// Clock of the block.
	localparam int CLK_PERIOD_NS = 40;

	// Bus widths and default burst shape.
	localparam int ADDR_W = 23;
	localparam int DATA_W = 16;
	localparam int LANE_W = 2;
	localparam int LATENCY_FAST = 5;
	localparam int LATENCY_SLOW = 4;
	localparam int BURST_LEN_DEF = 4;
	localparam int ARRAY_AW_DEF = 10;

	// Host-side spacing figures, kept for reference by the controller side.
	localparam int BURST_END_TO_STROBE_GAP_NS = 7;
	localparam int STOP_TO_STROBE_GAP_NS = 12;
	localparam int WRITE_READ_TURNAROUND_CLK = 1;
	localparam int BURST_END_TO_STROBE_GAP_CYC =
		(BURST_END_TO_STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STOP_TO_STROBE_GAP_CYC =
		(STOP_TO_STROBE_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Longest selection time; a longest time rounds down.
	localparam int BURST_CYCLE_TIME_NS = 2500;
	localparam int BURST_CYCLE_TIME_CYC = BURST_CYCLE_TIME_NS / CLK_PERIOD_NS;

	// Reset levels of the pin-facing flops.
	localparam logic PIN_HIGH_RST = 1'h1;
	localparam logic PIN_LOW_RST = 1'h0;

	// Burst sequencer states.
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_LAT,
		ST_RD,
		ST_WR,
		ST_DONE
	} bpsst_state_t;

endpackage : bpsst_pkg

// ==== hdl/bpsst_array.sv ====
`timescale 1ns/10ps
// Storage array with per-lane write enables and an asynchronous read port.
module bpsst_array #(
	parameter int AW = bpsst_pkg::ARRAY_AW_DEF
) (
	input wire logic mclk,
	input wire logic clk_en,
	input wire logic wr_en,
	input wire logic [bpsst_pkg::LANE_W-1:0] wr_lane,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [bpsst_pkg::DATA_W-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [bpsst_pkg::DATA_W-1:0] rd_data
);

	logic [bpsst_pkg::DATA_W-1:0] mem [0:(1 << AW)-1];

	// Each lane is written on its own so that half-word writes leave the other byte intact.
	always_ff @(posedge mclk) begin
		if (clk_en && wr_en) begin
			if (wr_lane[0]) begin
				mem[wr_addr][7:0] <= wr_data[7:0];
			end
			if (wr_lane[1]) begin
				mem[wr_addr][15:8] <= wr_data[15:8];
			end
		end
	end

	// Read is combinational so the sequencer can register the word at the beat edge.
	assign rd_data = mem[rd_addr];

endmodule : bpsst_array

// ==== dv/bpsst_host.sv ====
`timescale 1ns/10ps
// Host controller model: drives the strobes and write data for the bench.
module bpsst_host (
	input wire logic mclk,
	output logic clk_en,
	output logic cs_n,
	output logic addr_valid_n,
	output logic oe_n,
	output logic we_n,
	output logic upper_lane_n,
	output logic lower_lane_n,
	output logic burst_write_mode,
	output logic [bpsst_pkg::ADDR_W-1:0] addr,
	output logic [bpsst_pkg::DATA_W-1:0] dq_in
);
	logic wr_act = 1'h0;
	logic [bpsst_pkg::DATA_W-1:0] wd = 16'h0;
	logic [bpsst_pkg::DATA_W-1:0] junk = 16'h0;

	// Idle levels at time zero; the chip stays deselected until asked.
	initial begin
		{clk_en, cs_n, addr_valid_n, oe_n, we_n} = 5'h1f;
		{upper_lane_n, lower_lane_n, burst_write_mode} = 3'h0;
		addr = 23'h0;
	end

	// A released data bus toggles, so stale write data can never look valid.
	always @(posedge mclk) junk <= ~junk;
	assign dq_in = wr_act ? wd : junk;

	// Deselect; at least one idle edge follows before any new strobe.
	task automatic idle();
		@(posedge mclk) begin
			{cs_n, we_n, oe_n, addr_valid_n} <= 4'hf;
		end
	endtask : idle

	// Fresh strobe and address; returns at the edge that takes it.
	task automatic strobe(input logic wr, input logic [22:0] a);
		@(posedge mclk) begin
			{cs_n, addr_valid_n, we_n, oe_n} <= {2'h0, ~wr, wr};
			burst_write_mode <= 1'h1;
			addr <= a;
		end
		@(posedge mclk);
	endtask : strobe

	// Four-beat burst write; beat k lanes come from ln[2k+1:2k].
	task automatic wburst(input logic [22:0] a, input logic [3:0][15:0] d,
		input logic [7:0] ln);
		strobe(1'h1, a);
		addr_valid_n <= 1'h1;
		repeat (2) @(posedge mclk);
		for (int k = 0; k < 4; k++) begin
			@(posedge mclk) begin
				wd <= d[k];
				{upper_lane_n, lower_lane_n} <= ln[2*k +: 2];
				wr_act <= 1'h1;
			end
		end
		@(posedge mclk) wr_act <= 1'h0;
		idle();
	endtask : wburst

	// Asynchronous write; low keeps the strobe low for the whole access.
	task automatic awr(input logic [22:0] a, input logic [15:0] d, input logic low);
		@(posedge mclk) begin
			{cs_n, addr_valid_n, we_n, oe_n, burst_write_mode} <= 5'h02;
			addr <= a;
		end
		@(posedge mclk) addr_valid_n <= ~low;
		@(posedge mclk) begin
			wd <= d;
			{upper_lane_n, lower_lane_n} <= 2'h0;
			wr_act <= 1'h1;
		end
		@(posedge mclk) we_n <= 1'h1;
		@(posedge mclk) wr_act <= 1'h0;
		idle();
	endtask : awr
endmodule : bpsst_host

// ==== dv/bpsst_core_tb.sv ====
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s exp %h got %h", n, e, g); end end
// Self-checking bench for the burst core against the host model.
module bpsst_core_tb;
	logic mclk = 1'h0;
	logic rst_b = 1'h0;
	logic clk_en, cs_n, addr_valid_n, oe_n, we_n;
	logic upper_lane_n, lower_lane_n, burst_write_mode;
	logic [22:0] addr;
	logic [15:0] dq_in, dq_out;
	logic dq_oe, wait_n, wait_oe, proto_err, burst_overrun;
	logic [15:0] m [1024];
	int err_total = 0;
	int total_checks = 0;

	// Clock at 25 MHz.
	initial forever #20 mclk = ~mclk;

	bpsst_host u_h (.mclk(mclk), .clk_en(clk_en), .cs_n(cs_n),
		.addr_valid_n(addr_valid_n), .oe_n(oe_n), .we_n(we_n),
		.upper_lane_n(upper_lane_n), .lower_lane_n(lower_lane_n),
		.burst_write_mode(burst_write_mode), .addr(addr), .dq_in(dq_in));

	bpsst_core #(.LATENCY(bpsst_pkg::LATENCY_FAST)) u_dut (.mclk(mclk), .rst_b(rst_b),
		.clk_en(clk_en), .cs_n(cs_n), .addr_valid_n(addr_valid_n), .oe_n(oe_n),
		.we_n(we_n), .upper_lane_n(upper_lane_n), .lower_lane_n(lower_lane_n),
		.burst_write_mode(burst_write_mode), .addr(addr), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .wait_n(wait_n), .wait_oe(wait_oe),
		.burst_overrun(burst_overrun), .proto_err(proto_err));

	// Word k of a four-word linear burst wraps inside its aligned group.
	function automatic logic [9:0] idx(input logic [22:0] a, input int k);
		return (a[9:0] & 10'h3fc) | ((a[9:0] + 10'(k)) & 10'h003);
	endfunction : idx

	task automatic end_of_test();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// Burst write; the shadow memory keeps only the unmasked byte lanes.
	task automatic wr4(input logic [22:0] a, input logic [15:0] b, input logic [7:0] ln);
		logic [3:0][15:0] d;
		for (int k = 0; k < 4; k++) begin
			d[k] = b + 16'(k);
			if (!ln[2*k]) m[idx(a, k)][7:0] = d[k][7:0];
			if (!ln[2*k+1]) m[idx(a, k)][15:8] = d[k][15:8];
		end
		u_h.wburst(a, d, ln);
	endtask : wr4

	// Burst read of n words, optionally suspended after word one.
	task automatic rd(input logic [22:0] a, input logic [2:0] n, input logic sus,
		input logic hold);
		u_h.strobe(1'h0, a);
		if (!hold) u_h.addr_valid_n <= 1'h1;
		#1 `CHK("wait_oe", 1'h1, wait_oe)
		`CHK("wait_low", 1'h0, wait_n)
		for (int i = 1; i < 4; i++) begin
			@(posedge mclk) u_h.addr_valid_n <= 1'h1;
			#1 `CHK("wait_n", (i == 3) ? 1'h1 : 1'h0, wait_n)
		end
		for (int k = 0; k < n; k++) begin
			@(posedge mclk);
			if (sus && k == 1) u_h.clk_en <= 1'h0;
			#1 `CHK("rd_word", m[idx(a, k)], dq_out)
			`CHK("rd_oe", 1'h1, dq_oe)
			if (sus && k == 1) begin
				@(posedge mclk) u_h.oe_n <= 1'h1;
				#1 `CHK("sus_float", 1'h0, dq_oe)
				@(posedge mclk) begin
					u_h.oe_n <= 1'h0;
					u_h.clk_en <= 1'h1;
				end
				#1 `CHK("sus_hold", m[idx(a, 1)], dq_out)
				`CHK("sus_oe", 1'h1, dq_oe)
			end
		end
		u_h.idle();
		@(posedge mclk);
		#1 `CHK("stop_dq_oe", 1'h0, dq_oe)
		`CHK("stop_wait_oe", 1'h0, wait_oe)
	endtask : rd

	// Host faults: a strobe inside a running burst, then a selection held too long.
	task automatic misuse();
		u_h.strobe(1'h0, 23'h10);
		u_h.addr_valid_n <= 1'h1;
		@(posedge mclk) u_h.addr_valid_n <= 1'h0;
		@(posedge mclk) u_h.addr_valid_n <= 1'h1;
		#1 `CHK("proto_err", 1'h1, proto_err)
		@(posedge mclk);
		#1 `CHK("proto_err_end", 1'h0, proto_err)
		@(posedge mclk);
		#1 `CHK("fault_word", m[idx(23'h10, 0)], dq_out)
		`CHK("overrun_early", 1'h0, burst_overrun)
		repeat (bpsst_pkg::BURST_CYCLE_TIME_CYC - 5) @(posedge mclk);
		#1 `CHK("overrun_edge", 1'h0, burst_overrun)
		@(posedge mclk);
		#1 `CHK("overrun_set", 1'h1, burst_overrun)
		u_h.idle();
		@(posedge mclk);
		#1 `CHK("overrun_clear", 1'h0, burst_overrun)
	endtask : misuse

	// Main sequence; reads are only made of words written before.
	initial begin
		repeat (4) @(posedge mclk);
		rst_b <= 1'h1;
		#1 `CHK("rst_wait_n", 1'h1, wait_n)
		`CHK("rst_wait_oe", 1'h0, wait_oe)
		wr4(23'h10, 16'h1100, 8'h00);
		wr4(23'h10, 16'h2200, 8'h38);
		$display("test burst_write done");
		rd(23'h11, 3'h4, 1'h1, 1'h1);
		$display("test suspend_read done");
		rd(23'h10, 3'h1, 1'h0, 1'h0);
		rd(23'h12, 3'h4, 1'h0, 1'h0);
		$display("test stop_read done");
		misuse();
		$display("test host_fault done");
		wr4(23'h30, 16'h3300, 8'h00);
		rd(23'h30, 3'h4, 1'h0, 1'h0);
		m[10'h20] = 16'h5a5a;
		u_h.awr(23'h20, 16'h5a5a, 1'h0);
		rd(23'h20, 3'h1, 1'h0, 1'h0);
		m[10'h21] = 16'hc33c;
		u_h.awr(23'h21, 16'hc33c, 1'h1);
		rd(23'h20, 3'h2, 1'h0, 1'h0);
		$display("test async_turnaround done");
		end_of_test();
	end

	// A hang is cut short and reported as a mismatch.
	initial begin
		repeat (3000) @(posedge mclk);
		err_total++;
		$display("Error timeout exp finish got hang");
		end_of_test();
	end
endmodule : bpsst_core_tb
